/* File: flash_status_register_bits.sv */
// program/erase controller status register
`include "flash_status_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: erase-suspended bit is 1 while erase paused awaiting resume.
// R2: erase suspend lands within latency; an erase finishing first just completes.
// R3: resume command clears erase-suspended bit.
// R4: erase verify failure after maximum pulses sets erase-error bit.
// R5: erase-error sticky until clear-status or reset; host clears before erase.
// R6: program verify failure after maximum pulses sets program-error bit.
// R7: programming one over programmed bit at high supply sets program-error; code checks it in PEC_PROGRAM only, not buffered mode.
// R8: program-error sticky until clear-status or reset; host clears first.
// R9: program supply validity sampled once at each operation start.
// R10: supply below lockout sets supply-error and refuses operation.
// R11: supply-error and protect-error sticky until clear-status or reset.
// R12: program-suspended bit is 1 while program paused awaiting resume.
// R13: program suspend lands within latency; a program finishing first completes.
// R14: resume command clears program-suspended bit.
// R15: program or erase on locked block sets protect-error and aborts.
// R16: while busy, low bit 0 if addressed bank busy, else 1.
// R17: buffered mode low bit 0 means next word accepted, 1 not.
// R18: buffered mode: ready with low 0 is exit; ready with low 1 never.
// R19: ready bit 1 when controller idle, 0 while active.
// R20: status snapshot taken on falling enable, held until enable rises.
// R21: device drives state bits; error bits cleared only by clear-status or reset.
// R22: eight-bit status, ready at bit 7, low bit 0, upper lines zero.
module flash_status_register_bits
  import flash_status_pkg::*;
#(
  parameter int SUSPEND_LATENCY = `SUSPEND_LATENCY_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // commands from the command decoder, one-cycle pulses
  input wire logic program_start_i,
  input wire logic erase_start_i,
  input wire logic buf_program_start_i,
  input wire logic buf_program_exit_i,
  input wire logic suspend_cmd_i,
  input wire logic resume_cmd_i,
  input wire logic clear_status_i,
  // array engine
  input wire logic op_done_i,
  input wire logic verify_fail_i,
  input wire logic overprogram_i,
  input wire logic word_busy_i,
  input wire logic exit_done_i,
  input wire logic block_locked_i,
  input wire logic supply_valid_i,
  input wire logic supply_high_i,
  input wire logic addressed_bank_busy_i,
  // engine control
  output logic op_run_o,
  output logic op_abort_o,
  // bus
  input wire logic chip_en_b_i,
  input wire logic out_en_b_i,
  output logic [15:0] status_data_o,
  output logic [7:0] program_erase_status_o
);
  import flash_status_pkg::*;

  // ****************************************
  // controller state
  // ****************************************
  pec_state_t state;
  pec_state_t next_state;
  logic suspend_pending;
  logic supply_high_at_start;
  logic erase_error_bit;
  logic program_error_bit;
  logic supply_error_bit;
  logic block_protect_error_bit;
  logic start_any;
  logic start_ok;
  logic refuse;
  logic busy;
  logic suspend_due;
  logic controller_ready_bit;
  logic erase_suspended_bit;
  logic program_suspended_bit;
  logic bank_write_or_word_ready_bit;

  // ****************************************
  // command acceptance
  // ****************************************
  assign start_any = program_start_i || erase_start_i || buf_program_start_i;
  // an ignored start leaves the error bits and the supply sample alone, save a program start losing to a resume in PEC_ERS_SUSP
  assign start_ok = (state == PEC_IDLE) ? start_any : ((state == PEC_ERS_SUSP) && program_start_i);
  // supply checked only here, at the moment an operation begins
  assign refuse = start_ok && (!supply_valid_i || block_locked_i); // [R9] [R10] [R15]
  assign busy = (state == PEC_PROGRAM) || (state == PEC_ERASE);

  always_comb begin
    next_state = state;
    case (state)
      PEC_IDLE: begin
        if (start_any && !refuse) begin
          if (program_start_i) begin
            next_state = PEC_PROGRAM;
          end else if (erase_start_i) begin
            next_state = PEC_ERASE;
          end else begin
            next_state = PEC_BUF_PROGRAM;
          end
        end
      end
      PEC_PROGRAM: begin
        // completion beats a late suspend
        if (op_done_i) begin
          next_state = PEC_IDLE; // [R13]
        end else if (suspend_due) begin
          next_state = PEC_PRG_SUSP; // [R13]
        end
      end
      PEC_ERASE: begin
        if (op_done_i) begin
          next_state = PEC_IDLE; // [R2]
        end else if (suspend_due) begin
          next_state = PEC_ERS_SUSP; // [R2]
        end
      end
      PEC_PRG_SUSP: begin
        if (resume_cmd_i) begin
          next_state = PEC_PROGRAM; // [R14]
        end
      end
      PEC_ERS_SUSP: begin
        if (resume_cmd_i) begin
          next_state = PEC_ERASE; // [R3]
        end else if (program_start_i && !refuse) begin
          next_state = PEC_PROGRAM;
        end
      end
      PEC_BUF_PROGRAM: begin
        if (buf_program_exit_i) begin
          next_state = PEC_BUF_EXIT;
        end
      end
      PEC_BUF_EXIT: begin
        if (exit_done_i) begin
          next_state = PEC_IDLE;
        end
      end
      default: begin
        next_state = PEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= PEC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // suspend latency
  // ****************************************
  // one suspend in flight per busy stretch; repeats while waiting are ignored
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      suspend_pending <= 1'b0;
    end else if (!busy) begin
      suspend_pending <= 1'b0;
    end else if (suspend_cmd_i) begin
      suspend_pending <= 1'b1;
    end
  end

  // the pause is taken at the latency bound, the worst case the host must allow for
  suspend_timer #(
    .LATENCY(SUSPEND_LATENCY)
  ) u_suspend_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(busy && suspend_cmd_i && !suspend_pending),
    .cancel_i(!busy),
    .expired_o(suspend_due)
  );

  // ****************************************
  // sticky error bits
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      supply_high_at_start <= 1'b0;
    end else if (start_ok) begin
      supply_high_at_start <= supply_high_i; // [R9]
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      erase_error_bit <= `STAT_ERR_RESET;
    end else if (state == PEC_ERASE && op_done_i && verify_fail_i) begin
      erase_error_bit <= 1'b1; // [R4]
    end else if (clear_status_i) begin
      erase_error_bit <= 1'b0; // [R5] [R21]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      program_error_bit <= `STAT_ERR_RESET;
    end else if ((state == PEC_PROGRAM || state == PEC_BUF_PROGRAM) && op_done_i && verify_fail_i) begin
      program_error_bit <= 1'b1; // [R6]
    end else if (state == PEC_PROGRAM && overprogram_i && supply_high_at_start) begin
      program_error_bit <= 1'b1; // [R7]
    end else if (clear_status_i) begin
      program_error_bit <= 1'b0; // [R8] [R21]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      supply_error_bit <= `STAT_ERR_RESET;
    end else if (start_ok && !supply_valid_i) begin
      supply_error_bit <= 1'b1; // [R10]
    end else if (clear_status_i) begin
      supply_error_bit <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      block_protect_error_bit <= `STAT_ERR_RESET;
    end else if (start_ok && block_locked_i) begin
      block_protect_error_bit <= 1'b1; // [R15]
    end else if (clear_status_i) begin
      block_protect_error_bit <= 1'b0; // [R11]
    end
  end

  // ****************************************
  // state bits and assembly
  // ****************************************
  // suspend states report ready; of them only PEC_ERS_SUSP accepts new work, a program start
  assign controller_ready_bit = (state == PEC_IDLE) || (state == PEC_PRG_SUSP) ||
                                (state == PEC_ERS_SUSP) || (state == PEC_BUF_EXIT); // [R19] [R12]
  assign erase_suspended_bit = (state == PEC_ERS_SUSP); // [R1]
  assign program_suspended_bit = (state == PEC_PRG_SUSP); // [R12]

  // outside busy and buffered-program states the low bit reads 0, never the forbidden ready-with-one pair
  always_comb begin
    case (state)
      PEC_BUF_PROGRAM: begin
        bank_write_or_word_ready_bit = word_busy_i; // [R17] [R18]
      end
      PEC_BUF_EXIT: begin
        bank_write_or_word_ready_bit = 1'b0; // [R18]
      end
      PEC_PROGRAM, PEC_ERASE: begin
        bank_write_or_word_ready_bit = !addressed_bank_busy_i; // [R16]
      end
      default: begin
        bank_write_or_word_ready_bit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      program_erase_status_o <= `STAT_RESET_VALUE;
    end else begin
      program_erase_status_o[`STAT_READY_POS] <= controller_ready_bit; // [R22]
      program_erase_status_o[`STAT_ERS_SUSP_POS] <= erase_suspended_bit;
      program_erase_status_o[`STAT_ERS_ERR_POS] <= erase_error_bit;
      program_erase_status_o[`STAT_PRG_ERR_POS] <= program_error_bit;
      program_erase_status_o[`STAT_SUPPLY_ERR_POS] <= supply_error_bit;
      program_erase_status_o[`STAT_PRG_SUSP_POS] <= program_suspended_bit;
      program_erase_status_o[`STAT_PROT_ERR_POS] <= block_protect_error_bit;
      program_erase_status_o[`STAT_BANK_WORD_POS] <= bank_write_or_word_ready_bit;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_abort_o <= 1'b0;
    end else begin
      op_abort_o <= refuse; // [R10] [R15]
    end
  end

  // buffered mode counts as running so the engine keeps ownership of the array
  assign op_run_o = busy || (state == PEC_BUF_PROGRAM);

  status_latch u_status_latch (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .chip_en_b_i(chip_en_b_i),
    .out_en_b_i(out_en_b_i),
    .live_i(program_erase_status_o),
    .data_o(status_data_o)
  ); // [R20]
endmodule
`default_nettype wire

/* File: flash_status_params.svh */
// constants for the program/erase status register block
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// ****************************************
// status bit positions
// ****************************************
`define STAT_READY_POS 3'd7
`define STAT_ERS_SUSP_POS 3'd6
`define STAT_ERS_ERR_POS 3'd5
`define STAT_PRG_ERR_POS 3'd4
`define STAT_SUPPLY_ERR_POS 3'd3
`define STAT_PRG_SUSP_POS 3'd2
`define STAT_PROT_ERR_POS 3'd1
`define STAT_BANK_WORD_POS 3'd0

// ****************************************
// reset values and timing
// ****************************************
`define STAT_ERR_RESET 1'b0
`define STAT_RESET_VALUE 8'h80
`define SUSPEND_LATENCY_NS 20000
`define CLK_PERIOD_NS 10
`define SUSPEND_LATENCY_CYC ((`SUSPEND_LATENCY_NS) / (`CLK_PERIOD_NS))

`endif

/* File: flash_status_pkg.sv */
// types for the program/erase status register block
package flash_status_pkg;
  typedef enum logic [2:0] {
    PEC_IDLE,
    PEC_PROGRAM,
    PEC_ERASE,
    PEC_PRG_SUSP,
    PEC_ERS_SUSP,
    PEC_BUF_PROGRAM,
    PEC_BUF_EXIT
  } pec_state_t;
endpackage

/* File: suspend_timer.sv */
// bounded-latency timer for suspend requests
`timescale 1ns/1ps
`default_nettype none
module suspend_timer #(
  parameter int LATENCY = 2000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic start_i,
  input wire logic cancel_i,
  // result
  output logic expired_o
);
  logic [15:0] count;
  logic running;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 16'h0000;
      running <= 1'b0;
    end else if (cancel_i) begin
      running <= 1'b0;
    end else if (start_i) begin
      count <= 16'(LATENCY - 1);
      running <= 1'b1;
    end else if (running && count != 16'h0000) begin
      count <= count - 16'h0001;
    end else begin
      running <= 1'b0;
    end
  end

  // suspend must land no later than the latency bound
  assign expired_o = running && (count == 16'h0000);
endmodule
`default_nettype wire

/* File: status_latch.sv */
// status value snapshot taken on a falling bus enable
`timescale 1ns/1ps
`default_nettype none
module status_latch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus strobes, active low
  input wire logic chip_en_b_i,
  input wire logic out_en_b_i,
  // live value and snapshot
  input wire logic [7:0] live_i,
  output logic [15:0] data_o
);
  logic enabled_q;
  logic enabled;

  assign enabled = !chip_en_b_i && !out_en_b_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= enabled;
    end
  end

  // capture on the first cycle both strobes are low, hold until the next such capture
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= 16'h0000;
    end else if (enabled && !enabled_q) begin
      data_o <= {8'h00, live_i};
    end
  end
endmodule
`default_nettype wire

/* File: flash_status_sva.sv */
// assertions on the status register block ports
`timescale 1ns/1ps
`default_nettype none
module flash_status_sva #(
  parameter int SUSPEND_LATENCY = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // commands and engine
  input wire logic program_start_i,
  input wire logic erase_start_i,
  input wire logic buf_program_start_i,
  input wire logic suspend_cmd_i,
  input wire logic resume_cmd_i,
  input wire logic clear_status_i,
  input wire logic exit_done_i,
  input wire logic block_locked_i,
  input wire logic supply_valid_i,
  input wire logic addressed_bank_busy_i,
  // bus and outputs
  input wire logic chip_en_b_i,
  input wire logic out_en_b_i,
  input wire logic op_run_o,
  input wire logic op_abort_o,
  input wire logic [15:0] status_data_o,
  input wire logic [7:0] program_erase_status_o
);
  // ***
  // helpers
  // ***
  localparam int LIM = SUSPEND_LATENCY + 4;
  logic [7:0] s;
  logic [3:0] e;
  logic go, rd, bm;
  assign s = program_erase_status_o;
  assign e = {s[5:3], s[1]};
  assign go = (program_start_i | erase_start_i | buf_program_start_i) & !op_run_o & s[7] & !s[6] & !s[2] & !bm;
  assign rd = !chip_en_b_i & !out_en_b_i;
  // buffered mode tracker; a refused start never enters it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) bm <= 1'b0;
    else if (exit_done_i) bm <= 1'b0;
    else if (go & buf_program_start_i & !block_locked_i & supply_valid_i) bm <= 1'b1;
  end
  // cycles since a suspend while running, until ready shows; a counter keeps long latencies cheap
  logic [15:0] wait_n;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wait_n <= 16'h0000;
    else if (suspend_cmd_i & op_run_o & !bm & (wait_n == 16'h0000)) wait_n <= 16'h0001;
    else if (s[7]) wait_n <= 16'h0000;
    else if (wait_n != 16'h0000) wait_n <= wait_n + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ***
  // properties
  // ***
  property p_busy; $rose(op_run_o) |=> !s[7]; endproperty
  a_busy: assert property (p_busy) else $error("ready while running");
  property p_never; s[7] |-> !s[0]; endproperty
  a_never: assert property (p_never) else $error("ready with low bit");
  property p_supply; go & !supply_valid_i |=> op_abort_o ##1 s[3] & s[7]; endproperty
  a_supply: assert property (p_supply) else $error("bad supply missed");
  property p_lock; go & block_locked_i & supply_valid_i |=> op_abort_o ##1 s[1] & s[7]; endproperty
  a_lock: assert property (p_lock) else $error("lock missed");
  property p_sticky; |($past(e) & ~e) |-> $past(clear_status_i) | $past(clear_status_i, 2); endproperty
  a_sticky: assert property (p_sticky) else $error("error bit dropped");
  property p_resume; resume_cmd_i & (s[6] | s[2]) |=> ##1 !s[6] & !s[2] & !s[7]; endproperty
  a_resume: assert property (p_resume) else $error("resume missed");
  property p_susp; wait_n <= 16'(LIM); endproperty
  a_susp: assert property (p_susp) else $error("suspend late");
  property p_bank; !s[7] & !bm & $stable(addressed_bank_busy_i) |-> s[0] == !addressed_bank_busy_i; endproperty
  a_bank: assert property (p_bank) else $error("bank bit wrong");
  property p_snap; rd & !$past(rd) |=> status_data_o == {8'h00, $past(s)}; endproperty
  a_snap: assert property (p_snap) else $error("snapshot wrong");
  c_esusp: cover property (s[6]);
  c_psusp: cover property (s[2]);
  c_abort: cover property (op_abort_o);
endmodule
bind flash_status_register_bits flash_status_sva #(.SUSPEND_LATENCY(SUSPEND_LATENCY)) chk (.*);
`default_nettype wire

/* File: flash_host.sv */
// host model reading status snapshots over the bus strobes
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  // clock and data
  input wire logic clk_i,
  input wire logic [15:0] data_i,
  // strobes
  output logic chip_en_b_o,
  output logic out_en_b_o
);
  initial begin
    chip_en_b_o = 1'b1;
    out_en_b_o = 1'b1;
  end
  // both strobes fall together and hold across the loading edge
  task automatic rd(output logic [15:0] v);
    chip_en_b_o = 1'b0;
    out_en_b_o = 1'b0;
    @(posedge clk_i);
    #1 v = data_i;
    chip_en_b_o = 1'b1;
    out_en_b_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the status register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic er, lk, ok, hi, vf, ov, bb; logic [7:0] x;} row_t;
  logic clk_i, rst_b_i, vf, ov, wb, lk, ok, hi, bb, run, abort, ce_b, oe_b;
  logic [8:0] cmd;
  logic [15:0] snap, v;
  logic [7:0] st;
  int num_errors = 0;
  int n_compared = 0;
  row_t r;
  row_t rows [8] = '{
    '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h80}, '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h90},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'hA0}, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h80},
    '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h90}, '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h80},
    '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h88}, '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h82}};
  flash_status_register_bits #(.SUSPEND_LATENCY(8)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .program_start_i(cmd[0]), .erase_start_i(cmd[1]), .buf_program_start_i(cmd[2]),
    .buf_program_exit_i(cmd[3]), .suspend_cmd_i(cmd[4]), .resume_cmd_i(cmd[5]),
    .clear_status_i(cmd[6]), .op_done_i(cmd[7]), .exit_done_i(cmd[8]), .verify_fail_i(vf),
    .overprogram_i(ov), .word_busy_i(wb), .block_locked_i(lk), .supply_valid_i(ok),
    .supply_high_i(hi), .addressed_bank_busy_i(bb), .op_run_o(run), .op_abort_o(abort),
    .chip_en_b_i(ce_b), .out_en_b_i(oe_b), .status_data_o(snap), .program_erase_status_o(st));
  flash_host host (.clk_i(clk_i), .data_i(snap), .chip_en_b_o(ce_b), .out_en_b_o(oe_b));
  // ***
  // tasks
  // ***
  task automatic close_out;
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // an idle edge first keeps two pulses from touching cmd in one step
  task automatic pulse(input int b);
    tick(1);
    cmd = 9'h001 << b;
    tick(1);
    cmd = 9'h000;
  endtask
  task automatic see(input logic [7:0] x);
    tick(1);
    host.rd(v);
    chk({8'h00, st}, {8'h00, x});
    chk(v, {8'h00, x});
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 40 && st[7] !== 1'b1; i++) tick(1);
    if (st[7] !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask
  // ***
  // stimulus
  // ***
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_b_i, cmd, vf, ov, wb, lk} = '0;
    {ok, hi, bb} = 3'b111;
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    see(8'h80);
    foreach (rows[i]) begin
      r = rows[i];
      pulse(6);
      {lk, ok, hi, bb} = {r.lk, r.ok, r.hi, r.bb};
      pulse(r.er ? 1 : 0);
      chk({14'h0000, run, abort}, {14'h0000, !r.lk && r.ok, r.lk || !r.ok});
      if (!r.lk && r.ok) begin
        see({7'h00, !r.bb});
        ov = r.ov;
        tick(1);
        ov = 1'b0;
        vf = r.vf;
        pulse(7);
        vf = 1'b0;
      end
      see(r.x);
    end
    tick(20);
    see(8'h82);
    {lk, ok, hi, bb} = 4'h7;
    rst_b_i = 1'b0;
    tick(2);
    chk(snap, 16'h0000);
    chk({6'h00, run, abort, st}, 16'h0080);
    rst_b_i = 1'b1;
    see(8'h80);
    pulse(0);
    ok = 1'b0;
    tick(2);
    pulse(7);
    ok = 1'b1;
    see(8'h80);
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      pulse(4);
      wait_rdy();
      see(k ? 8'hC0 : 8'h84);
      pulse(5);
      see(8'h00);
      pulse(7);
      see(8'h80);
    end
    pulse(1);
    pulse(4);
    pulse(7);
    tick(12);
    see(8'h80);
    wb = 1'b1;
    pulse(2);
    see(8'h01);
    wb = 1'b0;
    see(8'h00);
    pulse(3);
    see(8'h80);
    pulse(8);
    see(8'h80);
    close_out();
  end
endmodule
`default_nettype wire
